//--- verilog/synth_pkg.sv
package synth_pkg;

    // register map, byte address on the bus
    localparam logic [7:0] SYNTH_CONTROL_ADDR = 8'h00;

    // field positions inside synth_control
    localparam int INPUT_DIV_LSB = 0;
    localparam int FEEDBACK_DIV_LSB = 4;
    localparam int RESERVED_LSB = 8;
    localparam int CLOCK_OUT_SEL_LSB = 10;
    localparam int CODEC_SEL_BIT = 12;
    localparam int POWER_DOWN_BIT = 13;
    localparam int ENABLE_BIT = 14;
    localparam int LOCK_BIT = 15;

    localparam logic [15:0] SYNTH_CONTROL_RESET = 16'h0000;

    // fixed codec divider: 6.5 input periods = 13 half periods, 7 high and 6 low
    localparam logic [7:0] CODEC_ALT_PERIOD = 8'h0d;
    localparam logic [7:0] CODEC_ALT_HIGH = 8'h07;

    // vco is prescaled by four ahead of the feedback up counter
    localparam int VCO_PRESCALE_SHIFT = 2;

    // lock detector must stay high this long before lock is reported
    localparam int CLK_PERIOD_NS = 50;
    localparam int LOCK_QUAL_NS = 800;
    localparam int LOCK_QUAL_CYCLES = (LOCK_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] LOCK_QUAL_LAST = 8'(LOCK_QUAL_CYCLES - 1);

    // clock output pin sources
    localparam logic [1:0] CLKO_CORE_PHASE = 2'b00;
    localparam logic [1:0] CLKO_RESERVED = 2'b01;
    localparam logic [1:0] CLKO_EXT = 2'b10;
    localparam logic [1:0] CLKO_EXT_HALF = 2'b11;

    typedef enum logic [1:0] {
        LOCK_IDLE = 2'b00,
        LOCK_QUALIFY = 2'b01,
        LOCK_HELD = 2'b10
    } lock_state_t;

endpackage

//--- verilog/half_period_divider.sv
`timescale 1ns/100ps
`default_nettype none

// counts half periods of a sampled clock; level is high for the first
// high_len of every period_len half periods, so odd ratios such as 6.5 work
module half_period_divider (
    input wire logic clk,
    input wire logic resetn,
    input wire logic step,
    input wire logic [7:0] period_len,
    input wire logic [7:0] high_len,
    output logic level
);

    typedef struct packed {
        logic [7:0] count;
        logic level;
    } div_state_t;

    div_state_t s;
    div_state_t next_s;

    always_comb begin
        next_s = s;
        if (step) begin
            // a shortened period after a ratio change wraps at once
            if (s.count >= period_len - 8'h01) begin
                next_s.count = 8'h00;
            end else begin
                next_s.count = s.count + 8'h01;
            end
            next_s.level = next_s.count < high_len;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign level = s.level;

endmodule

`default_nettype wire

//--- verilog/synth_clock_control.sv
`timescale 1ns/100ps
`default_nettype none

module synth_clock_control
    import synth_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic WB_CYC,
    input wire logic WB_STB,
    input wire logic WB_WE,
    input wire logic [7:0] WB_ADR,
    input wire logic [3:0] WB_SEL,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK,
    input wire logic EXT_CLOCK_INPUT,
    input wire logic PLL_VCO,
    input wire logic PLL_LOCK_DETECT,
    output logic CODEC_CLOCK,
    output logic PLL_REFERENCE,
    output logic PLL_FEEDBACK,
    output logic PLL_POWER_DOWN,
    output logic CORE_CLOCK,
    output logic CLOCK_OUTPUT_PIN
);

    typedef struct packed {
        logic [2:0] ext_sync;
        logic [2:0] vco_sync;
        logic [1:0] det_sync;
        logic [3:0] input_divider;
        logic [3:0] feedback_divider;
        logic [1:0] clock_out_select;
        logic codec_clock_select;
        logic power_down;
        logic enable;
        lock_state_t lock_state;
        logic [7:0] lock_count;
        logic sel_pll;
        logic ext_half;
        logic core_phase;
        logic ack;
        logic [31:0] rdata;
        logic codec_clock;
        logic pll_reference;
        logic pll_feedback;
        logic pll_power_down;
        logic core_clock;
        logic clock_out;
    } ctl_state_t;

    ctl_state_t s;
    ctl_state_t next_s;

    logic ext_lvl;
    logic vco_lvl;
    logic det_lvl;
    logic ext_step;
    logic ext_rise;
    logic vco_step;
    logic in_div_lvl;
    logic alt_div_lvl;
    logic fb_div_lvl;
    logic [7:0] in_high;
    logic [7:0] in_period;
    logic [7:0] fb_unit;
    logic [7:0] fb_high;
    logic [7:0] fb_period;
    logic [15:0] reg_view;
    logic wb_req;
    logic wb_hit;
    logic commit;

    // levels from the second stages, edges from second and third; the first stages feed nothing but them
    assign ext_lvl = s.ext_sync[1];
    assign vco_lvl = s.vco_sync[1];
    assign det_lvl = s.det_sync[1];
    assign ext_step = s.ext_sync[1] ^ s.ext_sync[2];
    assign ext_rise = s.ext_sync[1] & ~s.ext_sync[2];
    assign vco_step = s.vco_sync[1] ^ s.vco_sync[2];

    assign in_high = {4'h0, s.input_divider} + 8'h01;
    assign in_period = in_high << 1;
    assign fb_unit = {4'h0, s.feedback_divider} + 8'h01;
    assign fb_high = fb_unit << VCO_PRESCALE_SHIFT;
    assign fb_period = fb_unit << (VCO_PRESCALE_SHIFT + 1);

    half_period_divider u_input_div (
        .clk(CLK),
        .resetn(RESETN),
        .step(ext_step),
        .period_len(in_period),
        .high_len(in_high),
        .level(in_div_lvl)
    );

    half_period_divider u_codec_alt_div (
        .clk(CLK),
        .resetn(RESETN),
        .step(ext_step),
        .period_len(CODEC_ALT_PERIOD),
        .high_len(CODEC_ALT_HIGH),
        .level(alt_div_lvl)
    );

    half_period_divider u_feedback_div (
        .clk(CLK),
        .resetn(RESETN),
        .step(vco_step),
        .period_len(fb_period),
        .high_len(fb_high),
        .level(fb_div_lvl)
    );

    always_comb begin
        reg_view = SYNTH_CONTROL_RESET;
        reg_view[INPUT_DIV_LSB +: 4] = s.input_divider;
        reg_view[FEEDBACK_DIV_LSB +: 4] = s.feedback_divider;
        reg_view[RESERVED_LSB +: 2] = 2'b00;
        reg_view[CLOCK_OUT_SEL_LSB +: 2] = s.clock_out_select;
        reg_view[CODEC_SEL_BIT] = s.codec_clock_select;
        reg_view[POWER_DOWN_BIT] = s.power_down;
        reg_view[ENABLE_BIT] = s.enable;
        reg_view[LOCK_BIT] = (s.lock_state == LOCK_HELD);
    end

    assign wb_req = WB_CYC & WB_STB;
    assign wb_hit = (WB_ADR[7:2] == SYNTH_CONTROL_ADDR[7:2]);
    // a write lands on the edge where the master sees ack
    assign commit = s.ack & wb_req & WB_WE & wb_hit;

    always_comb begin
        logic [15:0] wr;
        logic new_pd;
        logic new_en;
        logic lock_clear;
        wr = reg_view;
        new_pd = s.power_down;
        new_en = s.enable;
        lock_clear = 1'b0;
        next_s = s;

        next_s.ext_sync = {s.ext_sync[1:0], EXT_CLOCK_INPUT};
        next_s.vco_sync = {s.vco_sync[1:0], PLL_VCO};
        next_s.det_sync = {s.det_sync[0], PLL_LOCK_DETECT};

        // bus: one wait state, ack for one cycle, unmapped reads zero
        if (wb_req && !s.ack) begin
            next_s.ack = 1'b1;
            next_s.rdata = wb_hit ? {16'h0000, reg_view} : 32'h0000_0000;
        end else begin
            next_s.ack = 1'b0;
        end

        if (commit) begin
            if (WB_SEL[0]) begin
                wr[7:0] = WB_DAT_I[7:0];
            end
            if (WB_SEL[1]) begin
                wr[15:8] = WB_DAT_I[15:8];
            end
            new_pd = wr[POWER_DOWN_BIT];
            new_en = wr[ENABLE_BIT];
            // power-down may not rise while enable is, or would be, set
            if (new_pd && !s.power_down && (s.enable || new_en)) begin
                new_pd = 1'b0;
            end
            // pll still down: enable cannot be granted in the same write
            if (new_pd && new_en) begin
                new_en = 1'b0;
            end
            next_s.input_divider = wr[INPUT_DIV_LSB +: 4];
            next_s.feedback_divider = wr[FEEDBACK_DIV_LSB +: 4];
            next_s.clock_out_select = wr[CLOCK_OUT_SEL_LSB +: 2];
            next_s.codec_clock_select = wr[CODEC_SEL_BIT];
            next_s.power_down = new_pd;
            next_s.enable = new_en;
            // lock bit position is never taken from the write data
            if ((wr[INPUT_DIV_LSB +: 4] != s.input_divider) ||
                (wr[FEEDBACK_DIV_LSB +: 4] != s.feedback_divider) ||
                (new_pd && !s.power_down)) begin
                lock_clear = 1'b1;
            end
        end

        // enable alone never reaches the lock tracker
        case (s.lock_state)
            LOCK_IDLE: begin
                if (!s.power_down) begin
                    next_s.lock_state = LOCK_QUALIFY;
                    next_s.lock_count = 8'h00;
                end
            end
            LOCK_QUALIFY: begin
                if (s.power_down) begin
                    next_s.lock_state = LOCK_IDLE;
                end else if (!det_lvl) begin
                    next_s.lock_count = 8'h00;
                end else if (s.lock_count == LOCK_QUAL_LAST) begin
                    next_s.lock_state = LOCK_HELD;
                end else begin
                    next_s.lock_count = s.lock_count + 8'h01;
                end
            end
            LOCK_HELD: begin
                if (s.power_down) begin
                    next_s.lock_state = LOCK_IDLE;
                end
            end
            default: begin
                next_s.lock_state = LOCK_IDLE;
            end
        endcase
        // the clear wins here: a stale lock after a retune would be unsafe
        if (lock_clear) begin
            next_s.lock_state = LOCK_IDLE;
            next_s.lock_count = 8'h00;
        end

        // change source only while both clocks sit low, so no pulse is cut
        if ((s.sel_pll != s.enable) && !ext_lvl && !vco_lvl) begin
            next_s.sel_pll = s.enable;
        end
        next_s.core_clock = s.sel_pll ? vco_lvl : ext_lvl;
        next_s.core_phase = s.core_clock;

        if (ext_rise) begin
            next_s.ext_half = ~s.ext_half;
        end
        case (s.clock_out_select)
            CLKO_CORE_PHASE: next_s.clock_out = s.core_phase;
            CLKO_RESERVED: next_s.clock_out = 1'b0;
            CLKO_EXT: next_s.clock_out = ext_lvl;
            CLKO_EXT_HALF: next_s.clock_out = s.ext_half;
            default: next_s.clock_out = 1'b0;
        endcase

        next_s.codec_clock = s.codec_clock_select ? alt_div_lvl : in_div_lvl;
        next_s.pll_reference = in_div_lvl;
        next_s.pll_feedback = fb_div_lvl;
        // no stop input exists: only the register bit powers the pll down
        next_s.pll_power_down = s.power_down;
    end

    // only the hardware reset clears the register; there is no soft reset path
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign WB_DAT_O = s.rdata;
    assign WB_ACK = s.ack;
    assign CODEC_CLOCK = s.codec_clock;
    assign PLL_REFERENCE = s.pll_reference;
    assign PLL_FEEDBACK = s.pll_feedback;
    assign PLL_POWER_DOWN = s.pll_power_down;
    assign CORE_CLOCK = s.core_clock;
    assign CLOCK_OUTPUT_PIN = s.clock_out;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    property p_codec_source;
        s.codec_clock_select && $stable(s.codec_clock_select)
            |=> CODEC_CLOCK == $past(alt_div_lvl);
    endproperty
    a_codec_source: assert property (p_codec_source) else $error("codec not on 6.5 path");

    property p_codec_divided;
        !s.codec_clock_select && $stable(s.codec_clock_select)
            |=> CODEC_CLOCK == PLL_REFERENCE;
    endproperty
    a_codec_divided: assert property (p_codec_divided) else $error("codec not on divider");

    property p_reference;
        1'b1 |=> PLL_REFERENCE == $past(in_div_lvl);
    endproperty
    a_reference: assert property (p_reference) else $error("pll reference wrong");

    property p_no_reserved_combo;
        !(s.enable && s.power_down);
    endproperty
    a_no_reserved_combo: assert property (p_no_reserved_combo) else $error("enable with power down");

    property p_power_pin;
        $rose(s.power_down) |=> PLL_POWER_DOWN ##1 PLL_POWER_DOWN == s.power_down;
    endproperty
    a_power_pin: assert property (p_power_pin) else $error("power down pin late");

    property p_lock_cleared;
        $rose(s.power_down) || (commit && (WB_DAT_I[3:0] != s.input_divider) && WB_SEL[0])
            |=> s.lock_state == LOCK_IDLE;
    endproperty
    a_lock_cleared: assert property (p_lock_cleared) else $error("lock not cleared");

    // held before the bypass write must still be held after it
    property p_lock_kept;
        $past(s.lock_state) == LOCK_HELD && $fell(s.enable) && !s.power_down
            && $stable(s.power_down) && $stable(s.input_divider) && $stable(s.feedback_divider)
            |-> s.lock_state == LOCK_HELD;
    endproperty
    a_lock_kept: assert property (p_lock_kept) else $error("lock lost on bypass");

    property p_lock_qualified;
        $rose(s.lock_state == LOCK_HELD) |-> $past(det_lvl) && $past(det_lvl, 8);
    endproperty
    a_lock_qualified: assert property (p_lock_qualified) else $error("lock without detector");

    property p_lock_read_only;
        commit && WB_SEL[1] && WB_DAT_I[LOCK_BIT] && s.lock_state != LOCK_HELD
            && s.lock_count != LOCK_QUAL_LAST |=> s.lock_state != LOCK_HELD;
    endproperty
    a_lock_read_only: assert property (p_lock_read_only) else $error("lock was written");

    property p_reserved_zero;
        WB_ACK |-> WB_DAT_O[9:8] == 2'b00 && WB_DAT_O[31:16] == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

    property p_switch_low;
        $changed(s.sel_pll) |-> !$past(ext_lvl) && !$past(vco_lvl) && !CORE_CLOCK;
    endproperty
    a_switch_low: assert property (p_switch_low) else $error("clock switch glitch");

    property p_ack_single;
        WB_ACK |=> !WB_ACK;
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("ack longer than one cycle");

    c_locked: cover property ($rose(s.lock_state == LOCK_HELD));
    c_to_pll: cover property ($rose(s.sel_pll));
    c_to_ext: cover property ($fell(s.sel_pll));
    c_refused_pd: cover property (commit && WB_SEL[1] && WB_DAT_I[POWER_DOWN_BIT] && s.enable);

endmodule

`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import synth_pkg::*;

    logic CLK, RESETN, cyc, stb, we, det, ack;
    logic ext = 1'b0;
    logic vco = 1'b0;
    logic codec, pref, fb, pdn, core, clko;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat_i, dat_o;
    logic [15:0] q;
    logic [2:0] ext_cnt = 3'd0;
    logic [1:0] vco_cnt = 2'd0;
    wire [4:0] mon = {clko, core, fb, pref, codec};
    int err_count, num_checks, n;

    synth_clock_control i_synth_clock_control (.CLK(CLK), .RESETN(RESETN), .WB_CYC(cyc),
        .WB_STB(stb), .WB_WE(we), .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_I(dat_i),
        .WB_DAT_O(dat_o), .WB_ACK(ack), .EXT_CLOCK_INPUT(ext), .PLL_VCO(vco),
        .PLL_LOCK_DETECT(det), .CODEC_CLOCK(codec), .PLL_REFERENCE(pref),
        .PLL_FEEDBACK(fb), .PLL_POWER_DOWN(pdn), .CORE_CLOCK(core),
        .CLOCK_OUTPUT_PIN(clko));

    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end

    // ext half period 3 cycles, vco half period 2 cycles: slow enough for the 3-flop samplers
    always @(posedge CLK) begin
        ext_cnt <= (ext_cnt == 3'd2) ? 3'd0 : ext_cnt + 3'd1;
        if (ext_cnt == 3'd2) ext <= ~ext;
        vco_cnt <= vco_cnt + 2'd1;
        if (vco_cnt[0]) vco <= ~vco;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle; entered right after either clock edge, leaves one idle cycle behind
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [15:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat_i <= {16'h0000, d};
        do begin
            @(posedge CLK);
            k++;
        end while (ack !== 1'b1 && k < 50);
        if (k >= 50) chk(32'h0, 32'h1);
        q = dat_o[15:0];
        chk({16'h0000, dat_o[31:16]}, 32'h0);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge CLK);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        wb(1'b1, a, 4'h3, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        wb(1'b0, a, 4'h0, 16'h0000);
        chk({16'h0000, q}, {16'h0000, exp});
    endtask

    // cycles from the call to the next rise of monitored clock idx, 300 if none
    task automatic rise(input int idx, output int cnt);
        logic p;
        cnt = 0;
        do begin
            p = mon[idx];
            @(negedge CLK);
            cnt++;
        end while (!(p === 1'b0 && mon[idx] === 1'b1) && cnt < 300);
    endtask

    // first two rises are skipped so a divider restarted by the write settles
    task automatic period(input int idx, input int exp);
        rise(idx, n);
        rise(idx, n);
        rise(idx, n);
        chk(32'(n), 32'(exp));
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge CLK);
    endtask

    task automatic final_report;
        $display("compares %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #(50 * 20000);
        err_count++;
        final_report();
    end

    initial begin
        err_count = 0;
        num_checks = 0;
        RESETN = 1'b0;
        {cyc, stb, we, det} = 4'h0;
        adr = 8'h00;
        sel = 4'h0;
        dat_i = 32'h0;
        idle(16);
        RESETN <= 1'b1;
        rd(SYNTH_CONTROL_ADDR, 16'h0000);
        wr(SYNTH_CONTROL_ADDR, 16'hffff);
        rd(SYNTH_CONTROL_ADDR, 16'h5cff);
        wr(SYNTH_CONTROL_ADDR, 16'h0000);
        wr(SYNTH_CONTROL_ADDR, 16'h2000);
        rd(SYNTH_CONTROL_ADDR, 16'h2000);
        chk({31'h0, pdn}, 32'h1);
        wr(SYNTH_CONTROL_ADDR, 16'h6000);
        rd(SYNTH_CONTROL_ADDR, 16'h2000);
        wr(SYNTH_CONTROL_ADDR, 16'h0012);
        idle(2);
        chk({31'h0, pdn}, 32'h0);
        period(0, 18);
        period(1, 18);
        period(2, 32);
        period(3, 6);
        wr(SYNTH_CONTROL_ADDR, 16'h1012);
        period(0, 39);
        period(1, 18);
        wr(SYNTH_CONTROL_ADDR, 16'h0812);
        period(4, 6);
        wr(SYNTH_CONTROL_ADDR, 16'h0c12);
        period(4, 12);
        wr(SYNTH_CONTROL_ADDR, 16'h0412);
        rise(4, n);
        chk(32'(n), 32'd300);
        wr(SYNTH_CONTROL_ADDR, 16'h0012);
        // a one-cycle dropout must restart the qualification count
        det <= 1'b1;
        idle(12);
        det <= 1'b0;
        idle(1);
        det <= 1'b1;
        idle(12);
        rd(SYNTH_CONTROL_ADDR, 16'h0012);
        idle(12);
        rd(SYNTH_CONTROL_ADDR, 16'h8012);
        wr(SYNTH_CONTROL_ADDR, 16'hc012);
        rd(SYNTH_CONTROL_ADDR, 16'hc012);
        period(3, 4);
        wr(SYNTH_CONTROL_ADDR, 16'h0012);
        period(4, 6);
        wr(SYNTH_CONTROL_ADDR, 16'h0012);
        rd(SYNTH_CONTROL_ADDR, 16'h8012);
        wr(SYNTH_CONTROL_ADDR, 16'h0013);
        rd(SYNTH_CONTROL_ADDR, 16'h0013);
        idle(30);
        wr(SYNTH_CONTROL_ADDR, 16'h0023);
        rd(SYNTH_CONTROL_ADDR, 16'h0023);
        idle(30);
        rd(SYNTH_CONTROL_ADDR, 16'h8023);
        wr(SYNTH_CONTROL_ADDR, 16'h4023);
        rd(SYNTH_CONTROL_ADDR, 16'hc023);
        wr(SYNTH_CONTROL_ADDR, 16'h0023);
        rd(SYNTH_CONTROL_ADDR, 16'h8023);
        wr(SYNTH_CONTROL_ADDR, 16'h2023);
        rd(SYNTH_CONTROL_ADDR, 16'h2023);
        idle(30);
        rd(SYNTH_CONTROL_ADDR, 16'h2023);
        wr(SYNTH_CONTROL_ADDR, 16'ha023);
        rd(SYNTH_CONTROL_ADDR, 16'h2023);
        wr(8'h04, 16'hffff);
        rd(8'h04, 16'h0000);
        rd(SYNTH_CONTROL_ADDR, 16'h2023);
        wb(1'b1, SYNTH_CONTROL_ADDR, 4'h1, 16'hffa5);
        rd(SYNTH_CONTROL_ADDR, 16'h20a5);
        wr(SYNTH_CONTROL_ADDR, 16'h1312);
        rd(SYNTH_CONTROL_ADDR, 16'h1012);
        // second hardware reset in mid-run clears everything, codec select too
        RESETN <= 1'b0;
        idle(2);
        RESETN <= 1'b1;
        rd(SYNTH_CONTROL_ADDR, 16'h0000);
        final_report();
    end
endmodule

`default_nettype wire
